// ---- src/sep_slave_ctrl.sv ----
// two-wire serial eeprom slave: bus protocol, sequential read, on-chip programming
`timescale 1ns/1ps

module sep_slave_ctrl #(
	parameter int unsigned PHASE_CNT = sep_pkg::PHASE_CYCLES,
	parameter int unsigned BULK_CNT  = sep_pkg::BULK_CYCLES,
	parameter int unsigned POR_CNT   = sep_pkg::POR_CYCLES
) (
	// clocks, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        scl_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// bus data pin, open drain
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// select and mode pins
	input  wire logic        select_bit_zero,
	input  wire logic        select_bit_one,
	input  wire logic        select_bit_two,
	input  wire logic        sel_zero_float,
	input  wire logic        bulk_erase_pin,
	// status
	output logic             prog_busy,
	output logic             por_busy
);
	import sep_pkg::*;

	sep_pins_t               pins_in;
	sep_pins_t               sync1_reg;
	sep_pins_t               sync2_reg;
	logic                    scl_prev_reg;
	logic                    sda_prev_reg;
	logic [7:0]              rx_shift_reg;
	logic [7:0]              mem [MEM_WORDS];
	sep_bus_state_t          st_reg;
	logic [3:0]              bit_cnt_reg;
	logic [9:0]              addr_reg;
	logic [7:0]              data_reg;
	logic [7:0]              tx_shift_reg;
	logic                    rd_first_reg;
	logic                    sda_oe_reg;
	logic                    sda_o_reg;
	sep_prog_state_t         pg_reg;
	sep_prog_state_t         pg_next;
	logic [TMR_W-1:0]        tmr_reg;
	logic [TMR_W-1:0]        tmr_next;
	sep_prog_req_t           preq_reg;
	logic                    prog_busy_reg;
	logic [TMR_W-1:0]        por_cnt_reg;
	logic                    por_busy_reg;

	// helper: select word decode against the pin levels
	function automatic logic sel_match(input logic [7:0] w, input logic s0, input logic s1, input logic s2);
		logic hit;
		hit = (w[SEL_PREFIX_MSB:SEL_PREFIX_LSB] == SEL_PREFIX) && (w[SEL_ZERO_POS] == s0);
		if (w[SEL_DIR_POS] == DIR_READ) begin
			hit = hit && (w[SEL_TWO_POS] == s2) && (w[SEL_ONE_POS] == s1);
		end
		return hit;
	endfunction

	function automatic logic [TMR_W-1:0] cnt_load(input int unsigned n);
		return TMR_W'(n - 1);
	endfunction

	assign pins_in = '{bulk_erase_pin: bulk_erase_pin, sel_zero_float: sel_zero_float,
		select_bit_two: select_bit_two, select_bit_one: select_bit_one,
		select_bit_zero: select_bit_zero, sda: sda_i, scl: scl_clk};

	// two-stage synchroniser for every pin; only stage two is looked at
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg    <= '1;
			sync2_reg    <= '1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else if (ce) begin
			sync1_reg    <= pins_in;
			sync2_reg    <= sync1_reg;
			scl_prev_reg <= sync2_reg.scl;
			sda_prev_reg <= sync2_reg.sda;
		end
	end

	logic scl_s;
	logic sda_s;
	logic wprot;
	logic sel0_eff;
	logic start_ev;
	logic stop_ev;
	logic rise_ev;
	logic fall_ev;
	logic [7:0] rx_byte;
	logic sel_hit;
	logic abort_ev;
	logic prog_go;
	logic bulk_req;

	// bus conditions from the synchronised levels
	assign scl_s    = sync2_reg.scl;
	assign sda_s    = sync2_reg.sda;
	assign wprot    = sync2_reg.sel_zero_float;
	assign sel0_eff = wprot ? 1'b0 : sync2_reg.select_bit_zero;
	assign start_ev = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_ev  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
	assign rise_ev  = scl_s && !scl_prev_reg;
	assign fall_ev  = !scl_s && scl_prev_reg;
	assign rx_byte  = rx_shift_reg;
	assign sel_hit  = sel_match(rx_byte, sel0_eff, sync2_reg.select_bit_one, sync2_reg.select_bit_two);
	assign abort_ev = ce && fall_ev && (bit_cnt_reg == BIT_ACK) && (st_reg == ST_SEL) && sel_hit
		&& (rx_byte[SEL_DIR_POS] == DIR_WRITE);
	assign prog_go  = ce && stop_ev && (st_reg == ST_WDONE) && (bit_cnt_reg <= BIT_STOP_MAX);
	assign bulk_req = sync2_reg.bulk_erase_pin && (addr_reg == BULK_ADDR) && (data_reg == BULK_DATA);

	// link side: data captured on the rising clock edge; stable through the low phase,
	// which is far longer than the synchroniser delay, so the ref side reads it safely
	always_ff @(posedge scl_clk or negedge nrst) begin
		if (!nrst) begin
			rx_shift_reg <= 8'h00;
		end else begin
			rx_shift_reg <= {rx_shift_reg[6:0], sda_i};
		end
	end

	// power-on lockout for programming requests
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			por_cnt_reg  <= '0;
			por_busy_reg <= 1'b1;
		end else if (ce && por_busy_reg) begin
			if (por_cnt_reg == cnt_load(POR_CNT)) begin
				por_busy_reg <= 1'b0;
			end else begin
				por_cnt_reg <= por_cnt_reg + TMR_W'(1);
			end
		end
	end

	// byte protocol, acknowledge and read shifter
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg       <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			addr_reg     <= 10'h000;
			data_reg     <= 8'hFF;
			tx_shift_reg <= 8'hFF;
			rd_first_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
			sda_o_reg    <= 1'b0;
		end else if (ce) begin
			if (stop_ev) begin
				st_reg      <= ST_IDLE;
				sda_oe_reg  <= 1'b0;
				bit_cnt_reg <= 4'h0;
			end else if (start_ev) begin
				// repeated start keeps the address counter for the read that follows
				st_reg      <= ST_SEL;
				sda_oe_reg  <= 1'b0;
				bit_cnt_reg <= 4'h0;
			end else if (st_reg != ST_IDLE && rise_ev) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (st_reg == ST_RD && bit_cnt_reg == BIT_ACK) begin
					if (rd_first_reg) begin
						tx_shift_reg <= mem[addr_reg];
						rd_first_reg <= 1'b0;
					end else if (!sda_s) begin
						addr_reg     <= addr_reg + 10'h001;
						tx_shift_reg <= mem[addr_reg + 10'h001];
					end else begin
						st_reg <= ST_IGN;
					end
				end
			end else if (st_reg != ST_IDLE && fall_ev) begin
				if (bit_cnt_reg == BIT_ACK) begin
					sda_oe_reg <= 1'b0;
					case (st_reg)
						ST_SEL: begin
							if (!sel_hit) begin
								st_reg <= ST_IGN;
							end else if (rx_byte[SEL_DIR_POS] == DIR_WRITE) begin
								sda_oe_reg     <= 1'b1;
								addr_reg[9:8]  <= rx_byte[SEL_TWO_POS:SEL_ONE_POS];
								st_reg         <= ST_WADDR;
							end else if (prog_busy_reg) begin
								st_reg <= ST_IGN;
							end else begin
								sda_oe_reg   <= 1'b1;
								rd_first_reg <= 1'b1;
								st_reg       <= ST_RD;
							end
						end
						ST_WADDR: begin
							addr_reg[7:0] <= rx_byte;
							sda_oe_reg    <= 1'b1;
							st_reg        <= ST_WDATA;
						end
						ST_WDATA: begin
							data_reg   <= rx_byte;
							sda_oe_reg <= 1'b1;
							st_reg     <= ST_WDONE;
						end
						ST_WDONE: begin
							// a fourth byte is not part of a write frame
							st_reg <= ST_IGN;
						end
						default: begin
						end
					endcase
				end else if (bit_cnt_reg == BIT_END) begin
					// end of acknowledge clock: release, or put out the first read bit
					bit_cnt_reg  <= 4'h0;
					sda_oe_reg   <= (st_reg == ST_RD) && !tx_shift_reg[7];
					tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
				end else if (st_reg == ST_RD && bit_cnt_reg != 4'h0) begin
					sda_oe_reg   <= !tx_shift_reg[7];
					tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
				end
			end
		end
	end

	// programming sequencer, next state
	always_comb begin
		pg_next  = pg_reg;
		tmr_next = tmr_reg;
		if (abort_ev) begin
			pg_next = PG_IDLE;
		end else begin
			case (pg_reg)
				PG_IDLE: begin
					if (prog_go && !por_busy_reg && !wprot) begin
						if (bulk_req) begin
							pg_next  = PG_BULK;
							tmr_next = cnt_load(BULK_CNT);
						end else if (mem[addr_reg] != ERASED_WORD) begin
							pg_next  = PG_ERASE;
							tmr_next = cnt_load(PHASE_CNT);
						end else if (data_reg != ERASED_WORD) begin
							pg_next  = PG_WRITE;
							tmr_next = cnt_load(PHASE_CNT);
						end
					end
				end
				PG_ERASE: begin
					if (tmr_reg == '0) begin
						pg_next  = (preq_reg.data != ERASED_WORD) ? PG_WRITE : PG_IDLE;
						tmr_next = cnt_load(PHASE_CNT);
					end else begin
						tmr_next = tmr_reg - TMR_W'(1);
					end
				end
				PG_WRITE, PG_BULK: begin
					if (tmr_reg == '0) begin
						pg_next = PG_IDLE;
					end else begin
						tmr_next = tmr_reg - TMR_W'(1);
					end
				end
				default: begin
					pg_next = PG_IDLE;
				end
			endcase
		end
	end

	// programming sequencer, state and latched request
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pg_reg        <= PG_IDLE;
			tmr_reg       <= '0;
			preq_reg      <= '{addr: 10'h000, data: 8'hFF};
			prog_busy_reg <= 1'b0;
		end else if (ce) begin
			pg_reg        <= pg_next;
			tmr_reg       <= tmr_next;
			prog_busy_reg <= (pg_next != PG_IDLE);
			if (pg_reg == PG_IDLE && pg_next != PG_IDLE) begin
				preq_reg <= '{addr: addr_reg, data: data_reg};
			end
		end
	end

	// cell array; not reset, contents are nonvolatile by nature
	always_ff @(posedge ref_clk) begin
		if (ce && !abort_ev && tmr_reg == '0) begin
			case (pg_reg)
				PG_ERASE: mem[preq_reg.addr] <= ERASED_WORD;
				PG_WRITE: mem[preq_reg.addr] <= mem[preq_reg.addr] & preq_reg.data;
				PG_BULK: begin
					for (int i = 0; i < MEM_WORDS; i++) begin
						mem[i] <= ERASED_WORD;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// outputs straight from flops
	assign sda_o     = sda_o_reg;
	assign sda_oe    = sda_oe_reg;
	assign prog_busy = prog_busy_reg;
	assign por_busy  = por_busy_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst || !ce);

	sequence s_sel_byte_done;
		fall_ev && bit_cnt_reg == BIT_ACK && st_reg == ST_SEL && sel_hit;
	endsequence

	sequence s_read_sel_busy;
		s_sel_byte_done ##0 rx_byte[SEL_DIR_POS] == DIR_READ && prog_busy_reg && !stop_ev && !start_ev;
	endsequence

	a_ack_on_write: assert property (s_sel_byte_done ##0 rx_byte[0] == DIR_WRITE && !stop_ev && !start_ev
		|=> sda_oe_reg && st_reg == ST_WADDR) else $error("write select not acknowledged");
	a_poll_no_ack: assert property (s_read_sel_busy |=> !sda_oe_reg && st_reg == ST_IGN)
		else $error("read select acknowledged while busy");
	a_abort_prog: assert property (abort_ev && pg_reg != PG_IDLE |=> pg_reg == PG_IDLE && !prog_busy_reg)
		else $error("write select did not abort programming");
	a_stop_release: assert property (stop_ev |=> !sda_oe_reg && st_reg == ST_IDLE)
		else $error("stop did not release data line");
	a_read_release: assert property (fall_ev && st_reg == ST_RD && bit_cnt_reg == BIT_ACK && !start_ev && !stop_ev
		|=> !sda_oe_reg && bit_cnt_reg == BIT_ACK) else $error("data line held in master ack slot");
	a_prog_start: assert property (pg_reg == PG_IDLE ##1 pg_reg != PG_IDLE |-> $past(prog_go))
		else $error("programming started without stop after write frame");
	a_addr_wrap: assert property (rise_ev && st_reg == ST_RD && bit_cnt_reg == BIT_ACK && !rd_first_reg && !sda_s
		&& addr_reg == LAST_ADDR && !stop_ev && !start_ev |=> addr_reg == 10'h000) else $error("no wrap");
	a_por_lock: assert property (por_busy_reg && pg_reg == PG_IDLE |=> pg_reg == PG_IDLE)
		else $error("programming accepted during power-on lockout");
	a_wprot_lock: assert property (wprot && pg_reg == PG_IDLE |=> pg_reg == PG_IDLE)
		else $error("programming accepted while protected");
	a_skip_write: assert property (pg_reg == PG_ERASE && tmr_reg == '0 && preq_reg.data == ERASED_WORD && !abort_ev
		|=> pg_reg == PG_IDLE) else $error("write phase not skipped");
	a_erase_skip: assert property (prog_go && !por_busy_reg && !wprot && !bulk_req && !abort_ev && pg_reg == PG_IDLE
		&& mem[addr_reg] == ERASED_WORD && data_reg != ERASED_WORD |=> pg_reg == PG_WRITE)
		else $error("erase phase not skipped");

endmodule

// ---- src/sep_pkg.sv ----
// shared constants and carrier types for the serial eeprom slave control
package sep_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned PROG_TYP_MS     = 10;
	localparam int unsigned PROG_MAX_MS     = 20;
	localparam int unsigned BULK_MAX_MS     = 20;
	localparam int unsigned POR_US          = 100;
	// erase and write each take half the typical cycle, so a full cycle stays under the maximum
	localparam int unsigned PHASE_US        = PROG_TYP_MS * 1000 / 2;
	localparam int unsigned PHASE_CYCLES    = PHASE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BULK_CYCLES     = BULK_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned POR_CYCLES      = POR_US * (CLK_HZ / 1_000_000);
	localparam int unsigned TMR_W           = 24;

	// memory geometry
	localparam int unsigned ADDR_W          = 10;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned MEM_WORDS       = 1024;

	// select word layout
	localparam logic [3:0]  SEL_PREFIX      = 4'hA;
	localparam int unsigned SEL_PREFIX_MSB  = 7;
	localparam int unsigned SEL_PREFIX_LSB  = 4;
	localparam int unsigned SEL_TWO_POS     = 3;
	localparam int unsigned SEL_ONE_POS     = 2;
	localparam int unsigned SEL_ZERO_POS    = 1;
	localparam int unsigned SEL_DIR_POS     = 0;
	localparam logic        DIR_WRITE       = 1'h0;
	localparam logic        DIR_READ        = 1'h1;

	// bit counter marks within one byte frame
	localparam logic [3:0]  BIT_ACK         = 4'h8;
	localparam logic [3:0]  BIT_END         = 4'h9;
	localparam logic [3:0]  BIT_STOP_MAX    = 4'h1;

	// data values
	localparam logic [7:0]  ERASED_WORD     = 8'hFF;
	localparam logic [9:0]  BULK_ADDR       = 10'h000;
	localparam logic [7:0]  BULK_DATA       = 8'hFF;
	localparam logic [9:0]  LAST_ADDR       = 10'h3FF;

	// pin bundle, sampled together through the synchroniser
	typedef struct packed {
		logic bulk_erase_pin;
		logic sel_zero_float;
		logic select_bit_two;
		logic select_bit_one;
		logic select_bit_zero;
		logic sda;
		logic scl;
	} sep_pins_t;

	// programming request latched at the stop condition
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] data;
	} sep_prog_req_t;

	typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_WADDR, ST_WDATA, ST_WDONE, ST_RD, ST_IGN} sep_bus_state_t;
	typedef enum logic [1:0] {PG_IDLE, PG_ERASE, PG_WRITE, PG_BULK} sep_prog_state_t;

endpackage

// ---- bench/sep_bus_master.sv ----
// two-wire bus master model for the serial eeprom slave
`timescale 1ns/1ps
module sep_bus_master (
	// time base
	input  wire logic ref_clk,
	// wire level and master pull-down
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	// idle bus: clock high, data left to the pull-up
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// data moves a quarter into the low phase, sampled at the end of the high phase
	task automatic clk_bit(input logic b, output logic seen);
		wait_n(5);
		sda_low <= ~b;
		wait_n(15);
		scl <= 1'h1;
		wait_n(20);
		seen = sda_line;
		scl <= 1'h0;
	endtask

	// start or repeated start: data falls with the clock high
	task automatic start_cond();
		wait_n(5);
		sda_low <= 1'h0;
		wait_n(15);
		scl <= 1'h1;
		wait_n(20);
		sda_low <= 1'h1;
		wait_n(20);
		scl <= 1'h0;
	endtask

	// stop: data rises with the clock high, then bus free time
	task automatic stop_cond();
		wait_n(5);
		sda_low <= 1'h1;
		wait_n(15);
		scl <= 1'h1;
		wait_n(20);
		sda_low <= 1'h0;
		wait_n(40);
	endtask

	// byte msb first, then an acknowledge clock with data released
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(b[i], ack);
		clk_bit(1'h1, ack);
	endtask

	// eight data clocks plus master acknowledge: low goes on, high ends
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'h1, s);
			d[i] = s;
		end
		clk_bit(~more, s);
	endtask
endmodule

// ---- bench/sep_slave_ctrl_test.sv ----
// self-checking bench for the serial eeprom slave control
`timescale 1ns/1ps
module sep_slave_ctrl_test;
	import sep_pkg::*;
	// small counts keep the run short
	localparam int PH = 600;
	localparam int BK = 1200;
	localparam int PR = 2000;
	logic       ref_clk;
	logic       scl_clk;
	logic       nrst;
	logic       sda_o;
	logic       sda_oe;
	logic       sda_low;
	logic       sel_zero;
	logic       sel_one;
	logic       sel_two;
	logic       sel_float;
	logic       bulk_pin;
	logic       prog_busy;
	logic       por_busy;
	int         miscompares;
	int         total_checks;
	int         busy_cnt;
	logic [7:0] mem [MEM_WORDS];
	// pull-up: line is low while either party pulls
	wire        sda_line = ~(sda_low | (sda_oe & ~sda_o));

	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// busy length measured apart from the main sequence
	always @(posedge ref_clk) if (prog_busy === 1'h1) busy_cnt <= busy_cnt + 1;

	sep_bus_master m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl_clk), .sda_low(sda_low));

	sep_slave_ctrl #(.PHASE_CNT(PH), .BULK_CNT(BK), .POR_CNT(PR)) dut (
		.ref_clk(ref_clk), .scl_clk(scl_clk), .nrst(nrst), .ce(1'h1), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe(sda_oe), .select_bit_zero(sel_zero), .select_bit_one(sel_one), .select_bit_two(sel_two),
		.sel_zero_float(sel_float), .bulk_erase_pin(bulk_pin), .prog_busy(prog_busy), .por_busy(por_busy));

	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_prog(input int bound);
		for (int n = 0; prog_busy !== 1'h0; n++) begin
			@(posedge ref_clk);
			if (n > bound) begin
				check("busy timeout", 1'h0, prog_busy);
				report_and_stop();
			end
		end
	endtask

	function automatic logic [7:0] selw(input logic [1:0] hi, input logic s0, input logic dir);
		return {SEL_PREFIX, hi, s0, dir};
	endfunction

	// select, address and data bytes; ack level expected on each
	task automatic send3(input logic [9:0] a, input logic [7:0] d, input logic s0, input logic exp);
		logic ack;
		m.start_cond();
		m.wr_byte(selw(a[9:8], s0, DIR_WRITE), ack);
		check("select ack", exp, ack);
		m.wr_byte(a[7:0], ack);
		check("address ack", exp, ack);
		m.wr_byte(d, ack);
		check("data ack", exp, ack);
	endtask

	task automatic poll(input logic exp);
		logic ack;
		logic [7:0] d;
		m.start_cond();
		m.wr_byte(selw({sel_two, sel_one}, sel_zero, DIR_READ), ack);
		check("poll ack", exp, ack);
		if (ack === 1'h0) m.rd_byte(1'h0, d);
		m.stop_cond();
	endtask

	// one programming cycle, polled while busy and after
	task automatic write_word(input logic [9:0] a, input logic [7:0] d, input logic count);
		int ph;
		ph = int'(mem[a] !== ERASED_WORD) + int'(d !== ERASED_WORD);
		send3(a, d, sel_zero, 1'h0);
		check("busy before stop", 1'h0, prog_busy);
		busy_cnt = 0;
		m.stop_cond();
		if (ph > 0) begin
			check("busy after stop", 1'h1, prog_busy);
			poll(1'h1);
		end
		wait_prog(3 * PH);
		if (count) check("phase count", 16'(ph), 16'((busy_cnt + PH / 2) / PH));
		poll(1'h0);
		check("release after stop", 1'h0, sda_oe);
		mem[a] = d;
	endtask

	// address set by write select and address, repeated start, read select
	task automatic read_seq(input logic [9:0] a, input int n);
		logic ack;
		logic [7:0] d;
		m.start_cond();
		m.wr_byte(selw(a[9:8], sel_zero, DIR_WRITE), ack);
		m.wr_byte(a[7:0], ack);
		m.start_cond();
		m.wr_byte(selw({sel_two, sel_one}, sel_zero, DIR_READ), ack);
		check("read select ack", 1'h0, ack);
		for (int i = 0; i < n; i++) begin
			m.rd_byte(i < n - 1, d);
			check("read data", mem[a + i[9:0]], d);
		end
		m.stop_cond();
		check("release after read", 1'h0, sda_oe);
	endtask

	initial begin
		logic       ack;
		logic [9:0] a;
		void'($urandom(32'hdab5e41a));
		nrst = 1'h0;
		sel_zero = 1'h1;
		sel_one = 1'h0;
		sel_two = 1'h1;
		sel_float = 1'h0;
		bulk_pin = 1'h0;
		miscompares = 0;
		total_checks = 0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		check("lockout flag", 1'h1, por_busy);
		check("idle output", 1'h0, sda_oe);
		// programming asked for during lockout is dropped
		send3(10'h155, 8'h00, sel_zero, 1'h0);
		m.stop_cond();
		check("busy in lockout", 1'h0, prog_busy);
		repeat (PR) @(posedge ref_clk);
		check("lockout end", 1'h0, por_busy);
		// total erase, pin opened just before the stop
		send3(BULK_ADDR, BULK_DATA, sel_zero, 1'h0);
		bulk_pin <= 1'h1;
		busy_cnt = 0;
		m.stop_cond();
		wait_prog(2 * BK);
		bulk_pin <= 1'h0;
		check("bulk time", 1'h1, busy_cnt > BK / 2 && busy_cnt <= BK + 8);
		foreach (mem[i]) mem[i] = ERASED_WORD;
		write_word(10'h3FF, 8'h5A, 1'h1);
		write_word(10'h3FF, 8'hFF, 1'h1); // erase only
		write_word(10'h3FF, 8'hC3, 1'h1); // write only
		write_word(10'h3FF, 8'h3C, 1'h1); // erase then write
		write_word(10'h000, 8'hFF, 1'h1); // both phases skipped
		write_word(10'h3FE, 8'h00, 1'h1);
		read_seq(10'h3FE, 4); // runs across the top
		for (int k = 0; k < 8; k++) begin
			a = 10'($urandom);
			sel_zero <= 1'($urandom);
			sel_one <= 1'($urandom);
			sel_two <= 1'($urandom);
			repeat (4) @(posedge ref_clk);
			write_word(a, 8'($urandom), 1'h1);
			read_seq(a, 2);
		end
		// a select for the other chip gets no answer
		m.start_cond();
		m.wr_byte(selw({~sel_two, sel_one}, sel_zero, DIR_READ), ack);
		check("foreign select", 1'h1, ack);
		m.stop_cond();
		send3(10'h0F0, 8'h00, ~sel_zero, 1'h1);
		m.stop_cond();
		check("foreign write", 1'h0, prog_busy);
		// write select while busy cuts programming short; short frame starts nothing
		a = 10'h2A5;
		send3(a, 8'h0F, sel_zero, 1'h0);
		m.stop_cond();
		check("busy before abort", 1'h1, prog_busy);
		m.start_cond();
		m.wr_byte(selw(a[9:8], sel_zero, DIR_WRITE), ack);
		check("abort select ack", 1'h0, ack);
		m.wr_byte(a[7:0], ack);
		m.stop_cond();
		check("busy after abort", 1'h0, prog_busy);
		write_word(a, 8'h3C, 1'h1); // cut cycle left the word as it was
		read_seq(a, 1);
		// floating select zero: no programming, bit zero must be 0
		sel_float <= 1'h1;
		sel_zero <= 1'h0;
		repeat (4) @(posedge ref_clk);
		send3(10'h111, 8'h00, 1'h0, 1'h0);
		m.stop_cond();
		check("protected write", 1'h0, prog_busy);
		m.start_cond();
		m.wr_byte(selw({sel_two, sel_one}, 1'h1, DIR_READ), ack);
		check("protected select", 1'h1, ack);
		m.stop_cond();
		read_seq(10'h3FE, 3);
		report_and_stop();
	end
endmodule
